// *** src/lcd_fmt_pkg.sv ***
package lcd_fmt_pkg;

    // panel types the formatter can drive
    typedef enum logic [1:0] {
        MODE_MONO_SINGLE   = 2'b00,
        MODE_COLOUR_SINGLE = 2'b01,
        MODE_DUAL          = 2'b10,
        MODE_TFT           = 2'b11
    } panel_mode_e;

    // tft colour depth per component
    typedef enum logic [1:0] {
        DEPTH_3 = 2'b00,
        DEPTH_4 = 2'b01,
        DEPTH_6 = 2'b10
    } tft_depth_e;

    // screen geometry
    localparam int H_PIXELS = 640;
    localparam int V_LINES  = 480;

    // link word layout
    localparam int COMP_W   = 6;
    localparam int LINK_W   = 3 * COMP_W;
    localparam int RED_LSB  = 2 * COMP_W;
    localparam int GRN_LSB  = COMP_W;
    localparam int BLU_LSB  = 0;
    localparam int UPPER_LSB = 0;
    localparam int LOWER_LSB = 8;
    localparam int STN_MAX_W = 8;

    // buffering
    localparam int FIFO_DEPTH = 8;

    // packing
    localparam int ACC_W = 16;
    localparam logic [4:0] STN_WIDE_BITS   = 5'h08;
    localparam logic [4:0] STN_NARROW_BITS = 5'h04;
    localparam logic [4:0] MONO_PIX_BITS   = 5'h01;
    localparam logic [4:0] COLOUR_PIX_BITS = 5'h03;
    localparam logic [5:0] DEPTH_3_MASK = 6'h38;
    localparam logic [5:0] DEPTH_4_MASK = 6'h3c;
    localparam logic [5:0] DEPTH_6_MASK = 6'h3f;

    // line and frame timing, in pixel clocks and lines
    localparam int H_CNT_W = 11;
    localparam int V_CNT_W = 9;
    localparam logic [H_CNT_W-1:0] WORDS_MONO_8   = H_CNT_W'(H_PIXELS / 8);
    localparam logic [H_CNT_W-1:0] WORDS_MONO_4   = H_CNT_W'(H_PIXELS / 4);
    localparam logic [H_CNT_W-1:0] WORDS_COLOUR_8 = H_CNT_W'(H_PIXELS * 3 / 8);
    localparam logic [H_CNT_W-1:0] WORDS_COLOUR_4 = H_CNT_W'(H_PIXELS * 3 / 4);
    localparam logic [H_CNT_W-1:0] WORDS_TFT      = H_CNT_W'(H_PIXELS);
    localparam logic [V_CNT_W-1:0] LINES_SINGLE   = V_CNT_W'(V_LINES);
    localparam logic [V_CNT_W-1:0] LINES_DUAL     = V_CNT_W'(V_LINES / 2);
    localparam logic [H_CNT_W-1:0] H_BLANK_CLOCKS   = 11'h010;
    localparam logic [H_CNT_W-1:0] LINE_SYNC_OFFSET = 11'h004;
    localparam logic [V_CNT_W-1:0] V_BLANK_LINES    = 9'h004;

    function automatic logic [H_CNT_W-1:0] words_per_line(input panel_mode_e mode, input logic wide);
        case (mode)
            MODE_TFT:           words_per_line = WORDS_TFT;
            MODE_COLOUR_SINGLE: words_per_line = wide ? WORDS_COLOUR_8 : WORDS_COLOUR_4;
            default:            words_per_line = wide ? WORDS_MONO_8 : WORDS_MONO_4;
        endcase
    endfunction

    function automatic logic [V_CNT_W-1:0] lines_per_frame(input panel_mode_e mode);
        lines_per_frame = (mode == MODE_DUAL) ? LINES_DUAL : LINES_SINGLE;
    endfunction

endpackage

// *** src/word_stream_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface word_stream_if #(
    parameter int WIDTH = 18
);
    logic [WIDTH-1:0] wr_data;
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] rd_data;
    logic             rd_valid;
    logic             rd_ready;

    modport fill  (output wr_data, output wr_valid, input wr_ready);
    modport drain (input rd_data, input rd_valid, output rd_ready);
    modport store (input wr_data, input wr_valid, output wr_ready,
                   output rd_data, output rd_valid, input rd_ready);
endinterface

`default_nettype wire

// *** src/sync_2ff.sv ***
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
    parameter int WIDTH = 1
) (
    // clock
    input  wire logic             clk_in,
    // data
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] stage1;

    // no reset: flushes in two edges
    always_ff @(posedge clk_in) begin
        stage1 <= d_in;
        q_out  <= stage1;
    end
endmodule

`default_nettype wire

// *** src/async_word_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none

module async_word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // write side
    input  wire logic   wr_clk_in,
    input  wire logic   wr_reset_in,
    // read side
    input  wire logic   rd_clk_in,
    input  wire logic   rd_reset_in,
    // both ports
    word_stream_if.store words
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_bin;
    logic [AW:0]      wr_gray;
    logic [AW:0]      rd_bin;
    logic [AW:0]      rd_gray;
    logic [AW:0]      rd_gray_w1;
    logic [AW:0]      rd_gray_w2;
    logic [AW:0]      wr_gray_r1;
    logic [AW:0]      wr_gray_r2;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    wire logic [AW:0] next_wr_bin = wr_bin + (AW+1)'(1);
    wire logic [AW:0] next_rd_bin = rd_bin + (AW+1)'(1);
    wire logic        full        = wr_gray == {~rd_gray_w2[AW:AW-1], rd_gray_w2[AW-2:0]};
    wire logic        empty       = rd_gray == wr_gray_r2;
    wire logic        push        = words.wr_valid && !full;
    wire logic        pop         = words.rd_ready && !empty;

    assign words.wr_ready = !full;
    assign words.rd_valid = !empty;
    assign words.rd_data  = mem[rd_bin[AW-1:0]];

    always_ff @(posedge wr_clk_in) begin
        if (push) begin
            mem[wr_bin[AW-1:0]] <= words.wr_data;
        end
    end

    always_ff @(posedge wr_clk_in) begin
        if (wr_reset_in) begin
            wr_bin     <= '0;
            wr_gray    <= '0;
            rd_gray_w1 <= '0;
            rd_gray_w2 <= '0;
        end else begin
            rd_gray_w1 <= rd_gray;
            rd_gray_w2 <= rd_gray_w1;
            if (push) begin
                wr_bin  <= next_wr_bin;
                wr_gray <= to_gray(next_wr_bin);
            end
        end
    end

    always_ff @(posedge rd_clk_in) begin
        if (rd_reset_in) begin
            rd_bin     <= '0;
            rd_gray    <= '0;
            wr_gray_r1 <= '0;
            wr_gray_r2 <= '0;
        end else begin
            wr_gray_r1 <= wr_gray;
            wr_gray_r2 <= wr_gray_r1;
            if (pop) begin
                rd_bin  <= next_rd_bin;
                rd_gray <= to_gray(next_rd_bin);
            end
        end
    end
endmodule

`default_nettype wire

// *** src/lcd_panel_data_formatter.sv ***
// How it works
// R01 - Single-scan stn words go out left to right along each line, top line first.
// R02 - The stn bus is 4 or 8 bits wide, set by bus_wide_in.
// R03 - The leftmost pixel of a word sits on its msb.
// R04 - Mono vga on an 8-bit single-scan bus is 480 lines of 80 words in raster order.
// R05 - Mono stn packs eight one-bit pixels per 8-bit word.
// R06 - Colour stn packs r, g, b subpixel bits in turn, 8/3 pixels per 8-bit word.
// R07 - Mono and colour stn packing are separate modes.
// R08 - Pixel clock, frame sync and line sync go out with the data.
// R09 - Dual-scan sends upper and lower halves on buses of 4 or 8 bits each.
// R10 - Dual-scan halves leave together; vga 4-bit halves are 240 lines of 160 words.
// R11 - Dual-scan keeps the bit order and timing outputs of single-scan.
// R12 - Panels that count fixed pixel clocks after line sync are not supported.
// R13 - A data-enable tft panel takes data only while the window enable is high.
// R14 - The window enable is always driven.
// R15 - Tft data has 3, 4 or 6 bits per colour on parallel rgb lines.
// R16 - Panel power sequencing is left to board logic.
// R17 - Line sync pulses once per line, frame sync once per frame, data only between line syncs.
`timescale 1ns/1ns
`default_nettype none

module lcd_panel_data_formatter
    import lcd_fmt_pkg::*;
(
    // system clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 reset_in,
    // configuration levels, change only while reset is held
    input  wire logic [1:0]           panel_mode_in,
    input  wire logic                 bus_wide_in,
    input  wire logic [1:0]           tft_depth_in,
    // pixel stream from video logic, rgb 6:6:6
    input  wire logic                 pixel_valid_in,
    output logic                      pixel_ready_out,
    input  wire logic [LINK_W-1:0]    pixel_upper_in,
    input  wire logic [LINK_W-1:0]    pixel_lower_in,
    // link clock
    input  wire logic                 link_clk_in,
    // panel timing
    output logic                      panel_pixel_clock_out,
    output logic                      panel_frame_sync_out,
    output logic                      panel_line_sync_out,
    output logic                      display_window_enable_out,
    // panel data, stn halves and tft rgb share the word
    output logic [STN_MAX_W-1:0]      upper_data_out,
    output logic [STN_MAX_W-1:0]      lower_data_out,
    output logic [COMP_W-1:0]         tft_red_out,
    output logic [COMP_W-1:0]         tft_green_out,
    output logic [COMP_W-1:0]         tft_blue_out,
    // status
    output logic                      underrun_out
);

    word_stream_if #(.WIDTH(LINK_W)) link_words ();

    // subpixel bits of one pixel, left aligned, first one on top
    function automatic logic [2:0] pick_bits(input logic [LINK_W-1:0] pix, input logic colour);
        if (colour) begin
            pick_bits = {pix[RED_LSB+COMP_W-1], pix[GRN_LSB+COMP_W-1], pix[BLU_LSB+COMP_W-1]}; // R06
        end else begin
            pick_bits = {pix[GRN_LSB+COMP_W-1], 2'b00}; // R05
        end
    endfunction

    // new bits go just below the ones already held
    function automatic logic [ACC_W-1:0] append_bits(input logic [ACC_W-1:0] acc,
                                                     input logic [4:0]       count,
                                                     input logic [2:0]       bits);
        append_bits = acc | ({bits, 13'h0000} >> count); // R03
    endfunction

    // the oldest bits of the accumulator form the bus word
    function automatic logic [STN_MAX_W-1:0] head_word(input logic [ACC_W-1:0] acc, input logic wide);
        head_word = wide ? acc[ACC_W-1:ACC_W-8] : {4'h0, acc[ACC_W-1:ACC_W-4]}; // R02
    endfunction

    function automatic logic [COMP_W-1:0] depth_cut(input logic [COMP_W-1:0] comp, input tft_depth_e depth);
        case (depth)
            DEPTH_3: depth_cut = comp & DEPTH_3_MASK;
            DEPTH_4: depth_cut = comp & DEPTH_4_MASK;
            default: depth_cut = comp & DEPTH_6_MASK;
        endcase
    endfunction

    logic [ACC_W-1:0] acc_upper;
    logic [ACC_W-1:0] acc_lower;
    logic [4:0]       acc_count;

    wire panel_mode_e   ref_mode   = panel_mode_e'(panel_mode_in);
    wire tft_depth_e    ref_depth  = tft_depth_e'(tft_depth_in);
    wire logic          is_tft     = ref_mode == MODE_TFT;
    wire logic          is_colour  = ref_mode == MODE_COLOUR_SINGLE;
    wire logic          is_dual    = ref_mode == MODE_DUAL;
    wire logic [4:0]    bus_bits   = bus_wide_in ? STN_WIDE_BITS : STN_NARROW_BITS; // R02
    wire logic [4:0]    pix_bits   = is_colour ? COLOUR_PIX_BITS : MONO_PIX_BITS; // R07
    wire logic          emit_due   = !is_tft && (acc_count >= bus_bits);
    wire logic          emit       = emit_due && link_words.wr_ready;
    wire logic          take_pixel = pixel_valid_in && pixel_ready_out && !is_tft;
    wire logic [2:0]    upper_bits = pick_bits(pixel_upper_in, is_colour);
    wire logic [2:0]    lower_bits = is_dual ? pick_bits(pixel_lower_in, is_colour) : 3'h0; // R09

    // stn stalls while a whole word waits, so fifo back-pressure reaches the source
    assign pixel_ready_out = is_tft ? link_words.wr_ready : !emit_due;

    logic [ACC_W-1:0] next_acc_upper;
    logic [ACC_W-1:0] next_acc_lower;
    logic [4:0]       next_acc_count;

    always_comb begin
        next_acc_upper = acc_upper;
        next_acc_lower = acc_lower;
        next_acc_count = acc_count;
        if (is_tft) begin
            next_acc_upper = '0;
            next_acc_lower = '0;
            next_acc_count = '0;
        end else if (emit) begin
            next_acc_upper = acc_upper << bus_bits; // R01
            next_acc_lower = acc_lower << bus_bits;
            next_acc_count = acc_count - bus_bits;
        end else if (take_pixel) begin
            next_acc_upper = append_bits(acc_upper, acc_count, upper_bits);
            next_acc_lower = append_bits(acc_lower, acc_count, lower_bits);
            next_acc_count = acc_count + pix_bits;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            acc_upper <= '0;
            acc_lower <= '0;
            acc_count <= '0;
        end else begin
            acc_upper <= next_acc_upper;
            acc_lower <= next_acc_lower;
            acc_count <= next_acc_count;
        end
    end

    // both halves share one link word so they can never drift apart
    wire logic [LINK_W-1:0] stn_word = {2'b00, head_word(acc_lower, bus_wide_in),
                                        head_word(acc_upper, bus_wide_in)}; // R10
    wire logic [LINK_W-1:0] tft_word = {depth_cut(pixel_upper_in[RED_LSB +: COMP_W], ref_depth),
                                        depth_cut(pixel_upper_in[GRN_LSB +: COMP_W], ref_depth),
                                        depth_cut(pixel_upper_in[BLU_LSB +: COMP_W], ref_depth)}; // R15

    assign link_words.wr_data  = is_tft ? tft_word : stn_word;
    assign link_words.wr_valid = is_tft ? pixel_valid_in : emit_due;

    logic                link_reset;

    async_word_fifo #(
        .WIDTH(LINK_W),
        .DEPTH(FIFO_DEPTH)
    ) word_fifo (
        .wr_clk_in   (ref_clk_in),
        .wr_reset_in (reset_in),
        .rd_clk_in   (link_clk_in),
        .rd_reset_in (link_reset),
        .words       (link_words)
    );

    logic [2:0]          link_cfg;
    logic                phase;
    logic [2:0]          start_cnt;
    logic [H_CNT_W-1:0]  h_cnt;
    logic [V_CNT_W-1:0]  v_cnt;
    logic [LINK_W-1:0]   panel_word;
    logic                frame_sync;
    logic                line_sync;
    logic                window_en;
    logic                link_underrun;

    sync_2ff #(.WIDTH(1)) reset_sync (
        .clk_in (link_clk_in),
        .d_in   (reset_in),
        .q_out  (link_reset)
    );

    // configuration is quasi static, two flops are enough
    sync_2ff #(.WIDTH(3)) cfg_sync (
        .clk_in (link_clk_in),
        .d_in   ({panel_mode_in, bus_wide_in}),
        .q_out  (link_cfg)
    );

    sync_2ff #(.WIDTH(1)) underrun_sync (
        .clk_in (ref_clk_in),
        .d_in   (link_underrun),
        .q_out  (underrun_out)
    );

    wire panel_mode_e        link_mode = panel_mode_e'(link_cfg[2:1]);
    wire logic               link_wide = link_cfg[0];
    wire logic [H_CNT_W-1:0] wpl       = words_per_line(link_mode, link_wide); // R04
    wire logic [V_CNT_W-1:0] lines     = lines_per_frame(link_mode); // R10
    wire logic [H_CNT_W-1:0] h_last    = wpl + H_BLANK_CLOCKS - 11'h001;
    wire logic [V_CNT_W-1:0] v_last    = lines + V_BLANK_LINES - 9'h001;
    wire logic               in_window = (h_cnt < wpl) && (v_cnt < lines); // R17
    // a few words bank up first, so the opening line never starves
    wire logic               started   = start_cnt == 3'h7;
    wire logic               advance   = phase && started;
    wire logic               pop       = advance && in_window && link_words.rd_valid;

    assign link_words.rd_ready = pop;

    // pixel clock is link clock over two; data moves on its falling edge
    always_ff @(posedge link_clk_in) begin
        if (link_reset) begin
            phase     <= 1'b0;
            start_cnt <= 3'h0;
        end else begin
            phase <= !phase; // R08
            if (start_cnt != 3'h7 && (start_cnt != 3'h0 || link_words.rd_valid)) begin
                start_cnt <= start_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (link_reset) begin
            h_cnt <= '0;
            v_cnt <= '0;
        end else if (advance) begin
            h_cnt <= (h_cnt == h_last) ? '0 : h_cnt + 11'h001; // R01
            if (h_cnt == h_last) begin
                v_cnt <= (v_cnt == v_last) ? '0 : v_cnt + 9'h001;
            end
        end
    end

    // fixed clock-count panel types get no special timing here
    always_ff @(posedge link_clk_in) begin
        if (link_reset) begin
            panel_word <= '0;
            window_en  <= 1'b0;
            line_sync  <= 1'b0;
            frame_sync <= 1'b0;
        end else if (advance) begin
            panel_word <= pop ? link_words.rd_data : '0; // R12
            window_en  <= in_window; // R14
            line_sync  <= h_cnt == (wpl + LINE_SYNC_OFFSET); // R17
            frame_sync <= v_cnt == v_last; // R11
        end
    end

    // sticky until reset
    always_ff @(posedge link_clk_in) begin
        if (link_reset) begin
            link_underrun <= 1'b0;
        end else if (advance && in_window && !link_words.rd_valid) begin
            link_underrun <= 1'b1;
        end
    end

    assign panel_pixel_clock_out     = phase;
    assign panel_frame_sync_out      = frame_sync;
    assign panel_line_sync_out       = line_sync;
    assign display_window_enable_out = window_en; // R13
    assign upper_data_out            = panel_word[UPPER_LSB +: STN_MAX_W]; // R09
    assign lower_data_out            = panel_word[LOWER_LSB +: STN_MAX_W];
    assign tft_red_out               = panel_word[RED_LSB +: COMP_W];
    assign tft_green_out             = panel_word[GRN_LSB +: COMP_W];
    assign tft_blue_out              = panel_word[BLU_LSB +: COMP_W];

endmodule

`default_nettype wire

// *** verif/lcd_panel_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// de-type sink, power taken as sequenced by the board
module lcd_panel_model (
    // panel timing
    input  wire logic       pixel_clock_in,
    input  wire logic       window_enable_in,
    // panel data
    input  wire logic [7:0] upper_in,
    input  wire logic [7:0] lower_in,
    input  wire logic [5:0] red_in,
    input  wire logic [5:0] green_in,
    input  wire logic [5:0] blue_in
);
    logic [33:0] got_q[$];

    always @(posedge pixel_clock_in) begin
        if (window_enable_in === 1'b1) begin
            got_q.push_back({red_in, green_in, blue_in, lower_in, upper_in});
        end
    end
endmodule

`default_nettype wire

// *** verif/lcd_fmt_chk.sv ***
`timescale 1ns/1ns
`default_nettype none

module lcd_fmt_chk
    import lcd_fmt_pkg::*;
(
    // link clock and reset
    input  wire logic                 link_clk_in,
    input  wire logic                 reset_in,
    // configuration
    input  wire logic [1:0]           panel_mode_in,
    input  wire logic                 bus_wide_in,
    input  wire logic [1:0]           tft_depth_in,
    // panel side
    input  wire logic                 panel_pixel_clock_out,
    input  wire logic                 panel_frame_sync_out,
    input  wire logic                 panel_line_sync_out,
    input  wire logic                 display_window_enable_out,
    input  wire logic [STN_MAX_W-1:0] upper_data_out,
    input  wire logic [STN_MAX_W-1:0] lower_data_out,
    input  wire logic [COMP_W-1:0]    tft_red_out,
    input  wire logic [COMP_W-1:0]    tft_green_out,
    input  wire logic [COMP_W-1:0]    tft_blue_out
);
    default clocking cb @(posedge link_clk_in); endclocking
    default disable iff (reset_in);

    // link edges per active line, two per pixel clock
    wire  [11:0] run_expected = (panel_mode_in == 2'b11) ? 12'h500 :
                                (panel_mode_in == 2'b01) ? (bus_wide_in ? 12'h1e0 : 12'h3c0) :
                                (bus_wide_in ? 12'h0a0 : 12'h140);
    wire  [5:0]  low_mask = (tft_depth_in == 2'b00) ? 6'h07 : (tft_depth_in == 2'b01) ? 6'h03 : 6'h00;
    wire  [33:0] all_data = {upper_data_out, lower_data_out, tft_red_out, tft_green_out, tft_blue_out};
    logic [11:0] run;

    // window is low in reset, which clears it
    always_ff @(posedge link_clk_in) begin
        run <= display_window_enable_out ? run + 12'h001 : 12'h000;
    end

    property p_pixel_clock_half;
        panel_pixel_clock_out |=> !panel_pixel_clock_out;
    endproperty
    a_pixel_clock_half: assert property (p_pixel_clock_half) else $error("pixel clock high too long");
    property p_data_stable_at_rise;
        $rose(panel_pixel_clock_out) |-> $stable(all_data) && $stable(display_window_enable_out);
    endproperty
    a_data_stable_at_rise: assert property (p_data_stable_at_rise) else $error("data moved at pixel clock rise");
    property p_window_moves_on_fall;
        $changed(display_window_enable_out) |-> $fell(panel_pixel_clock_out);
    endproperty
    a_window_moves_on_fall: assert property (p_window_moves_on_fall) else $error("window moved off the fall");
    property p_line_sync_width;
        $rose(panel_line_sync_out) |=> panel_line_sync_out ##1 !panel_line_sync_out;
    endproperty
    a_line_sync_width: assert property (p_line_sync_width) else $error("line sync not one pixel clock");
    property p_syncs_outside_window;
        panel_line_sync_out || panel_frame_sync_out |-> !display_window_enable_out;
    endproperty
    a_syncs_outside_window: assert property (p_syncs_outside_window) else $error("sync inside window");
    property p_line_length;
        $fell(display_window_enable_out) |-> run == run_expected;
    endproperty
    a_line_length: assert property (p_line_length) else $error("active line length wrong");
    property p_blank_data_zero;
        !display_window_enable_out |-> all_data == 34'h0;
    endproperty
    a_blank_data_zero: assert property (p_blank_data_zero) else $error("data outside window");
    property p_narrow_bus;
        panel_mode_in != 2'b11 && !bus_wide_in |-> upper_data_out[7:4] == 4'h0 && lower_data_out[7:4] == 4'h0;
    endproperty
    a_narrow_bus: assert property (p_narrow_bus) else $error("narrow bus high nibble set");
    property p_single_lower_idle;
        !panel_mode_in[1] |-> lower_data_out == 8'h00;
    endproperty
    a_single_lower_idle: assert property (p_single_lower_idle) else $error("lower bus used in single scan");
    property p_tft_depth;
        panel_mode_in == 2'b11 |-> ((tft_red_out | tft_green_out | tft_blue_out) & low_mask) == 6'h00;
    endproperty
    a_tft_depth: assert property (p_tft_depth) else $error("tft low bits beyond depth");
endmodule

bind lcd_panel_data_formatter lcd_fmt_chk i_chk (
    .link_clk_in, .reset_in, .panel_mode_in, .bus_wide_in, .tft_depth_in, .panel_pixel_clock_out,
    .panel_frame_sync_out, .panel_line_sync_out, .display_window_enable_out, .upper_data_out,
    .lower_data_out, .tft_red_out, .tft_green_out, .tft_blue_out
);

`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic        ref_clk_in = 1'b0;
    logic        link_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [1:0]  panel_mode_in = 2'b00;
    logic        bus_wide_in = 1'b1;
    logic [1:0]  tft_depth_in = 2'b00;
    logic        pixel_valid_in = 1'b0;
    logic [17:0] pixel_upper_in = 18'h00000;
    logic [17:0] pixel_lower_in = 18'h00000;
    wire         pixel_ready_out;
    wire         pck, fs, ls, de, underrun;
    wire  [7:0]  upper, lower;
    wire  [5:0]  red, green, blue;
    int          errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    integer      seed = 32'h780f;
    logic [17:0] exp_q[$];
    logic        up_bits[$];
    logic        low_bits[$];

    always #5 ref_clk_in = ~ref_clk_in;
    always #24 link_clk_in = ~link_clk_in;

    lcd_panel_data_formatter i_dut (
        .ref_clk_in, .reset_in, .panel_mode_in, .bus_wide_in, .tft_depth_in, .pixel_valid_in, .pixel_ready_out,
        .pixel_upper_in, .pixel_lower_in, .link_clk_in, .panel_pixel_clock_out(pck), .panel_frame_sync_out(fs),
        .panel_line_sync_out(ls), .display_window_enable_out(de), .upper_data_out(upper),
        .lower_data_out(lower), .tft_red_out(red), .tft_green_out(green), .tft_blue_out(blue),
        .underrun_out(underrun)
    );

    lcd_panel_model i_panel (
        .pixel_clock_in(pck), .window_enable_in(de), .upper_in(upper), .lower_in(lower),
        .red_in(red), .green_in(green), .blue_in(blue)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] seen);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // reference packer, msb first
    task automatic model_take(input logic [17:0] up, input logic [17:0] lo);
        logic [7:0] wu;
        logic [7:0] wl;
        logic [5:0] m;
        int         w;
        w = bus_wide_in ? 8 : 4;
        m = (tft_depth_in == 2'b00) ? 6'h38 : (tft_depth_in == 2'b01) ? 6'h3c : 6'h3f;
        if (panel_mode_in == 2'b11) begin
            exp_q.push_back({up[17:12] & m, up[11:6] & m, up[5:0] & m});
            return;
        end
        if (panel_mode_in == 2'b01) begin
            up_bits.push_back(up[17]);
            up_bits.push_back(up[11]);
        end
        up_bits.push_back(panel_mode_in == 2'b01 ? up[5] : up[11]);
        if (panel_mode_in == 2'b10) begin
            low_bits.push_back(lo[11]);
        end
        while (up_bits.size() >= w) begin
            wu = 8'h00;
            wl = 8'h00;
            for (int k = 0; k < w; k++) begin
                wu = {wu[6:0], up_bits.pop_front()};
                if (panel_mode_in == 2'b10) begin
                    wl = {wl[6:0], low_bits.pop_front()};
                end
            end
            exp_q.push_back({2'b00, wl, wu});
        end
    endtask

    task automatic run_config(input logic [1:0] mode, input logic wide, input logic [1:0] depth, input int lines);
        int          n;
        int          t;
        logic        rdy;
        logic [33:0] got;
        @(posedge ref_clk_in);
        #1 reset_in = 1'b1;
        @(posedge ref_clk_in);
        #1 panel_mode_in = mode;
        bus_wide_in = wide;
        tft_depth_in = depth;
        repeat (20) @(posedge ref_clk_in);
        #1 exp_q.delete();
        up_bits.delete();
        low_bits.delete();
        i_panel.got_q.delete();
        reset_in = 1'b0;
        pixel_upper_in = 18'($random(seed));
        pixel_lower_in = 18'($random(seed));
        pixel_valid_in = 1'b1;
        n = 0;
        // hold each pixel until taken
        while (n < lines * 640) begin
            @(negedge ref_clk_in);
            rdy = pixel_ready_out;
            @(posedge ref_clk_in);
            #1 if (rdy === 1'b1) begin
                model_take(pixel_upper_in, pixel_lower_in);
                n++;
                pixel_upper_in = 18'($random(seed));
                pixel_lower_in = 18'($random(seed));
            end
        end
        pixel_valid_in = 1'b0;
        t = 0;
        while (i_panel.got_q.size() < exp_q.size() && t < 20000) begin
            @(posedge ref_clk_in);
            t++;
        end
        check("word count", 34'(exp_q.size()), 34'(i_panel.got_q.size() < exp_q.size() ? i_panel.got_q.size() : exp_q.size()));
        while (exp_q.size() > 0 && i_panel.got_q.size() > 0) begin
            got = i_panel.got_q.pop_front();
            check("panel word", {16'h0, exp_q.pop_front()}, {16'h0, mode == 2'b11 ? got[33:16] : {2'b00, got[15:0]}});
        end
        // stream stopped: next active word underruns
        t = 0;
        while (underrun !== 1'b1 && t < 20000) begin
            @(posedge ref_clk_in);
            t++;
        end
        check("underrun", 34'h1, {33'h0, underrun});
    endtask

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 100000) begin
            errors++;
            $display("CHECK FAILED run time expected %0d seen %0d", 100000, cycles);
            close_out();
        end
    end

    initial begin
        run_config(2'b00, 1'b1, 2'b00, 2);
        run_config(2'b00, 1'b0, 2'b00, 1);
        run_config(2'b01, 1'b1, 2'b00, 1);
        run_config(2'b01, 1'b0, 2'b00, 1);
        run_config(2'b10, 1'b1, 2'b00, 1);
        run_config(2'b10, 1'b0, 2'b00, 2);
        for (int i = 0; i < 4; i++) begin
            run_config(2'b11, 1'b0, 2'(i), 1);
        end
        close_out();
    end
endmodule

`default_nettype wire
